// *** inc/mixer_amp_params.svh ***
// Register offsets, field positions and reset values of the mixer amplifiers.
// Assumes inclusion by the design modules only; the package does not include it.
`ifndef MIXER_AMP_PARAMS_SVH
`define MIXER_AMP_PARAMS_SVH

`define OFS_INPUT_MIX1_CONTROL 8'h2C
`define OFS_INPUT_MIX1_GAIN 8'h2D
`define OFS_INPUT_MIX2_CONTROL 8'h2E
`define OFS_INPUT_MIX2_GAIN 8'h2F
`define OFS_LEFT_OUT_MIX_CONTROL 8'hCC
`define OFS_LEFT_OUT_MIX_GAIN 8'hCD
`define OFS_RIGHT_OUT_MIX_CONTROL 8'hCE
`define OFS_RIGHT_OUT_MIX_GAIN 8'hCF

`define BIT_AMP_ENABLE 7
`define BIT_AMP_MUTE 6
`define BIT_AMP_RAMP 5
`define BIT_AMP_CROSSING 4
`define BIT_MIX_ENABLE 3
`define IN_GAIN_MSB 3
`define OUT_GAIN_MSB 1

`define RST_IN_CONTROL 8'h48
`define RST_IN_GAIN 4'h3
`define RST_OUT_ENABLE 1'h0
`define RST_OUT_GAIN 2'h3

// Gains in tenths of a dB
`define IN_GAIN_BASE_TENTH_DB (-45)
`define IN_GAIN_STEP_TENTH_DB 15
`define OUT_GAIN_BASE_TENTH_DB (-15)
`define OUT_GAIN_STEP_TENTH_DB 5

// Cycles between ramp steps at 10 MHz, 100 us
`define RAMP_STEP_TIME_US 100
`define CLOCK_MHZ 10
`define RAMP_STEP_CYCLES (`RAMP_STEP_TIME_US * `CLOCK_MHZ)

`endif

// *** inc/mixer_amp_pkg.sv ***
// Types shared by the mixer amplifier control bank.
// Uses nothing from the params header; it has no include.
package mixer_amp_pkg;

    typedef enum logic [1:0] {
        GAIN_IDLE,
        GAIN_RAMP,
        GAIN_WAIT_CROSS
    } gain_state_t;

    typedef struct packed {
        logic enable;
        logic mute;
        logic ramp;
        logic crossing_sync;
        logic mix_enable;
    } in_control_t;

    typedef struct packed {
        logic powered;
        logic silenced;
        logic mixing;
        logic [3:0] gain_code;
        // Nine bits: the top code reaches 180 tenths of a dB
        logic signed [8:0] gain_tenth_db;
    } in_amp_state_t;

    typedef struct packed {
        logic powered;
        logic [1:0] gain_code;
        logic signed [7:0] gain_tenth_db;
        logic gain_reserved;
    } out_amp_state_t;

endpackage

// *** rtl/in_gain_stepper.sv ***
// Applies a requested input amplifier gain code: at once, stepped, or at a
// zero crossing. Assumes zero_cross is a one-cycle pulse from the signal path.
`timescale 1ns/1ps
`include "mixer_amp_params.svh"

module in_gain_stepper #(
    parameter int STEP_CYCLES = `RAMP_STEP_CYCLES
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [3:0] target,
    input wire logic ramp,
    input wire logic crossing_sync,
    input wire logic zero_cross,
    output logic [3:0] applied,
    output logic busy
);
    localparam int CW = $clog2(STEP_CYCLES + 1);
    mixer_amp_pkg::gain_state_t state;
    logic [CW-1:0] tick;

    assign busy = (state != mixer_amp_pkg::GAIN_IDLE);

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state <= mixer_amp_pkg::GAIN_IDLE;
            applied <= `RST_IN_GAIN;
            tick <= '0;
        end else begin
            unique case (state)
                mixer_amp_pkg::GAIN_IDLE: begin
                    tick <= '0;
                    if (target != applied) begin
                        if (ramp) begin
                            state <= mixer_amp_pkg::GAIN_RAMP;
                        end else if (crossing_sync) begin
                            state <= mixer_amp_pkg::GAIN_WAIT_CROSS;
                        end else begin
                            applied <= target;
                        end
                    end
                end
                mixer_amp_pkg::GAIN_RAMP: begin
                    if (!ramp || target == applied) begin
                        state <= mixer_amp_pkg::GAIN_IDLE;
                    end else if (tick == CW'(STEP_CYCLES - 1)) begin
                        tick <= '0;
                        if (target > applied) begin
                            applied <= applied + 4'h1;
                        end else begin
                            applied <= applied - 4'h1;
                        end
                    end else begin
                        tick <= tick + CW'(1);
                    end
                end
                mixer_amp_pkg::GAIN_WAIT_CROSS: begin
                    if (ramp || !crossing_sync || target == applied) begin
                        state <= mixer_amp_pkg::GAIN_IDLE;
                    end else if (zero_cross) begin
                        applied <= target;
                        state <= mixer_amp_pkg::GAIN_IDLE;
                    end
                end
                default: begin
                    state <= mixer_amp_pkg::GAIN_IDLE;
                end
            endcase
        end
    end
endmodule

// *** rtl/out_gain_decode.sv ***
// Decodes an output amplifier gain code into tenths of a dB.
// Assumes the code is held steady by the register bank.
`timescale 1ns/1ps
`include "mixer_amp_params.svh"

module out_gain_decode (
    input wire logic [1:0] code,
    output logic signed [7:0] tenth_db,
    output logic reserved
);
    always_comb begin
        reserved = (code == 2'h0);
        if (code == 2'h0) begin
            tenth_db = 8'sh00;
        end else begin
            tenth_db = 8'(`OUT_GAIN_BASE_TENTH_DB
                + `OUT_GAIN_STEP_TENTH_DB * int'(code));
        end
    end
endmodule

// *** rtl/mixer_amp_gain_control.sv ***
// Control register bank for two input mixer amplifiers and two output
// mixer amplifiers. Assumes a plain register port driven by software and
// one-cycle zero-crossing pulses from each input signal path.
//
// Notes on behaviour
// - An input mixer amplifier is powered only while its enable bit 7 is 1; reset 0.
// - An input mixer amplifier is silenced while its mute bit 6 is 1; reset 1.
// - With ramp bit 5 set, ramping wins and the zero-cross bit is ignored.
// - With ramp and zero-cross bits off, a new input gain code takes effect at once.
// - With zero-cross bit 4 set and ramp off, gain waits for a zero crossing.
// - An input mixer combines sources only while mix-enable bit 3 is 1; reset 1.
// - Input gain code decodes to -4.5 dB plus 1.5 dB per step; resets to 3.
// - An output mixer amplifier is enabled by bit 7; reset 0.
// - Output gain 01/10/11 give -1.0/-0.5/0.0 dB; 00 reserved; reset 3.
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`include "mixer_amp_params.svh"

module mixer_amp_gain_control #(
    parameter int RAMP_STEP = `RAMP_STEP_CYCLES
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [7:0] reg_address,
    input wire logic [7:0] reg_write_data,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_read_data,
    input wire logic [1:0] zero_cross,
    output mixer_amp_pkg::in_amp_state_t in_amp_a,
    output mixer_amp_pkg::in_amp_state_t in_amp_b,
    output mixer_amp_pkg::out_amp_state_t out_amp_left,
    output mixer_amp_pkg::out_amp_state_t out_amp_right,
    output logic [1:0] gain_busy
);
    mixer_amp_pkg::in_control_t in_ctrl [2];
    logic [3:0] in_gain [2];
    logic [3:0] in_applied [2];
    logic out_enable [2];
    logic [1:0] out_gain [2];
    logic signed [7:0] out_db [2];
    logic out_reserved [2];

    function automatic logic [7:0] pack_control(
        input mixer_amp_pkg::in_control_t c
    );
        logic [7:0] v;
        v = 8'h00;
        v[`BIT_AMP_ENABLE] = c.enable;
        v[`BIT_AMP_MUTE] = c.mute;
        v[`BIT_AMP_RAMP] = c.ramp;
        v[`BIT_AMP_CROSSING] = c.crossing_sync;
        v[`BIT_MIX_ENABLE] = c.mix_enable;
        return v;
    endfunction

    function automatic mixer_amp_pkg::in_control_t unpack_control(
        input logic [7:0] v
    );
        mixer_amp_pkg::in_control_t c;
        c.enable = v[`BIT_AMP_ENABLE];
        c.mute = v[`BIT_AMP_MUTE];
        c.ramp = v[`BIT_AMP_RAMP];
        c.crossing_sync = v[`BIT_AMP_CROSSING];
        c.mix_enable = v[`BIT_MIX_ENABLE];
        return c;
    endfunction

    function automatic logic signed [8:0] in_gain_db(input logic [3:0] code);
        return 9'(`IN_GAIN_BASE_TENTH_DB
            + `IN_GAIN_STEP_TENTH_DB * int'(code));
    endfunction

    // Input amplifier control registers
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            in_ctrl[0] <= unpack_control(`RST_IN_CONTROL);
            in_ctrl[1] <= unpack_control(`RST_IN_CONTROL);
        end else if (reg_write) begin
            if (reg_address == `OFS_INPUT_MIX1_CONTROL) begin
                in_ctrl[0] <= unpack_control(reg_write_data);
            end
            if (reg_address == `OFS_INPUT_MIX2_CONTROL) begin
                in_ctrl[1] <= unpack_control(reg_write_data);
            end
        end
    end

    // Input amplifier gain requests
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            in_gain[0] <= `RST_IN_GAIN;
            in_gain[1] <= `RST_IN_GAIN;
        end else if (reg_write) begin
            if (reg_address == `OFS_INPUT_MIX1_GAIN) begin
                in_gain[0] <= reg_write_data[`IN_GAIN_MSB:0];
            end
            if (reg_address == `OFS_INPUT_MIX2_GAIN) begin
                in_gain[1] <= reg_write_data[`IN_GAIN_MSB:0];
            end
        end
    end

    // Output amplifier registers
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            out_enable[0] <= `RST_OUT_ENABLE;
            out_enable[1] <= `RST_OUT_ENABLE;
            out_gain[0] <= `RST_OUT_GAIN;
            out_gain[1] <= `RST_OUT_GAIN;
        end else if (reg_write) begin
            unique case (reg_address)
                `OFS_LEFT_OUT_MIX_CONTROL: begin
                    out_enable[0] <= reg_write_data[`BIT_AMP_ENABLE];
                end
                `OFS_RIGHT_OUT_MIX_CONTROL: begin
                    out_enable[1] <= reg_write_data[`BIT_AMP_ENABLE];
                end
                `OFS_LEFT_OUT_MIX_GAIN: begin
                    out_gain[0] <= reg_write_data[`OUT_GAIN_MSB:0];
                end
                `OFS_RIGHT_OUT_MIX_GAIN: begin
                    out_gain[1] <= reg_write_data[`OUT_GAIN_MSB:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Read port: data stand in the cycle after the strobe only
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            reg_read_data <= 8'h00;
        end else if (!reg_read) begin
            reg_read_data <= 8'h00;
        end else begin
            unique case (reg_address)
                `OFS_INPUT_MIX1_CONTROL:
                    reg_read_data <= pack_control(in_ctrl[0]);
                `OFS_INPUT_MIX2_CONTROL:
                    reg_read_data <= pack_control(in_ctrl[1]);
                `OFS_INPUT_MIX1_GAIN:
                    reg_read_data <= {4'h0, in_gain[0]};
                `OFS_INPUT_MIX2_GAIN:
                    reg_read_data <= {4'h0, in_gain[1]};
                `OFS_LEFT_OUT_MIX_CONTROL:
                    reg_read_data <= {out_enable[0], 7'h00};
                `OFS_RIGHT_OUT_MIX_CONTROL:
                    reg_read_data <= {out_enable[1], 7'h00};
                `OFS_LEFT_OUT_MIX_GAIN:
                    reg_read_data <= {6'h00, out_gain[0]};
                `OFS_RIGHT_OUT_MIX_GAIN:
                    reg_read_data <= {6'h00, out_gain[1]};
                default:
                    reg_read_data <= 8'h00;
            endcase
        end
    end

    genvar i;
    generate
        for (i = 0; i < 2; i++) begin : g_in
            in_gain_stepper #(
                .STEP_CYCLES(RAMP_STEP)
            ) u_step (
                .clock(clock),
                .resetn(resetn),
                .target(in_gain[i]),
                .ramp(in_ctrl[i].ramp),
                .crossing_sync(in_ctrl[i].crossing_sync),
                .zero_cross(zero_cross[i]),
                .applied(in_applied[i]),
                .busy(gain_busy[i])
            );
            out_gain_decode u_out (
                .code(out_gain[i]),
                .tenth_db(out_db[i]),
                .reserved(out_reserved[i])
            );
        end
    endgenerate

    // Amplifier state seen by the analog path
    always_comb begin
        in_amp_a.powered = in_ctrl[0].enable;
        in_amp_a.silenced = in_ctrl[0].mute | ~in_ctrl[0].enable;
        in_amp_a.mixing = in_ctrl[0].mix_enable;
        in_amp_a.gain_code = in_applied[0];
        in_amp_a.gain_tenth_db = in_gain_db(in_applied[0]);
        in_amp_b.powered = in_ctrl[1].enable;
        in_amp_b.silenced = in_ctrl[1].mute | ~in_ctrl[1].enable;
        in_amp_b.mixing = in_ctrl[1].mix_enable;
        in_amp_b.gain_code = in_applied[1];
        in_amp_b.gain_tenth_db = in_gain_db(in_applied[1]);
        out_amp_left.powered = out_enable[0];
        out_amp_left.gain_code = out_gain[0];
        out_amp_left.gain_tenth_db = out_db[0];
        out_amp_left.gain_reserved = out_reserved[0];
        out_amp_right.powered = out_enable[1];
        out_amp_right.gain_code = out_gain[1];
        out_amp_right.gain_tenth_db = out_db[1];
        out_amp_right.gain_reserved = out_reserved[1];
    end
endmodule

// *** verification/mixer_amp_gain_control_assertions.sv ***
// Concurrent checks on the ports of the mixer amplifier control bank.
// Assumes the package is compiled first; bound to every instance.
`timescale 1ns/1ps

module mixer_amp_checker #(
    parameter int RAMP_STEP = 4
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [7:0] reg_address,
    input wire logic [7:0] reg_write_data,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_read_data,
    input wire logic [1:0] zero_cross,
    input mixer_amp_pkg::in_amp_state_t in_amp_a,
    input mixer_amp_pkg::in_amp_state_t in_amp_b,
    input mixer_amp_pkg::out_amp_state_t out_amp_left,
    input mixer_amp_pkg::out_amp_state_t out_amp_right,
    input wire logic [1:0] gain_busy
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    in_power_a: assert property (reg_write && reg_address == 8'h2C |=>
        in_amp_a.powered == $past(reg_write_data[7])) else $error("power");
    in_silence_a: assert property (reg_write && reg_address == 8'h2C |=>
        in_amp_a.silenced == ($past(reg_write_data[6])
        || !$past(reg_write_data[7]))) else $error("silence");
    instant_gain_a: assert property (reg_write && reg_address == 8'h2D
        ##1 !gain_busy[0] [*2] |-> in_amp_a.gain_code
        == $past(reg_write_data[3:0], 2)) else $error("instant gain");
    mix_enable_a: assert property (reg_write && reg_address == 8'h2E |=>
        in_amp_b.mixing == $past(reg_write_data[3])) else $error("mixing");
    in_db_a: assert property ($signed(in_amp_a.gain_tenth_db)
        == -45 + 15 * int'(in_amp_a.gain_code)) else $error("input dB");
    out_power_a: assert property (reg_write && reg_address == 8'hCE |=>
        out_amp_right.powered == $past(reg_write_data[7])) else $error("out");
    out_db_a: assert property (out_amp_left.gain_code != 2'h0 |->
        $signed(out_amp_left.gain_tenth_db)
        == -15 + 5 * int'(out_amp_left.gain_code)) else $error("out dB");
    out_gain_a: assert property (reg_write && reg_address == 8'hCD |=>
        out_amp_left.gain_code == $past(reg_write_data[1:0])) else $error("og");
    ctrl_reserved_a: assert property (reg_read && reg_address == 8'h2C |=>
        reg_read_data[2:0] == 3'h0) else $error("reserved control bits");
    out_reserved_a: assert property (reg_read && reg_address == 8'hCC |=>
        reg_read_data[6:0] == 7'h00) else $error("reserved output bits");
    unmapped_a: assert property (reg_read && reg_address == 8'h30 |=>
        reg_read_data == 8'h00) else $error("unmapped read");
endmodule

bind mixer_amp_gain_control mixer_amp_checker #(.RAMP_STEP(RAMP_STEP)) u_chk (
    .clock(clock), .resetn(resetn), .reg_address(reg_address),
    .reg_write_data(reg_write_data), .reg_write(reg_write),
    .reg_read(reg_read), .reg_read_data(reg_read_data),
    .zero_cross(zero_cross), .in_amp_a(in_amp_a), .in_amp_b(in_amp_b),
    .out_amp_left(out_amp_left), .out_amp_right(out_amp_right),
    .gain_busy(gain_busy));

// *** verification/mixer_amp_gain_control_tb.sv ***
// Self-checking bench for the mixer amplifier control bank.
// Assumes the package, design and checker are compiled before it.
`timescale 1ns/1ps

module mixer_amp_gain_control_tb;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] reg_address = 8'h00;
    logic [7:0] reg_write_data = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [7:0] reg_read_data;
    logic [1:0] zero_cross = 2'h0;
    logic [1:0] gain_busy;
    mixer_amp_pkg::in_amp_state_t in_amp_a;
    mixer_amp_pkg::in_amp_state_t in_amp_b;
    mixer_amp_pkg::out_amp_state_t out_amp_left;
    mixer_amp_pkg::out_amp_state_t out_amp_right;
    int bad_count = 0;
    int checks_done = 0;
    int n;
    logic [7:0] d;
    logic [7:0] ofs [8] = '{8'h2C, 8'h2D, 8'h2E, 8'h2F,
                            8'hCC, 8'hCD, 8'hCE, 8'hCF};
    logic [7:0] rst [8] = '{8'h48, 8'h03, 8'h48, 8'h03,
                            8'h00, 8'h03, 8'h00, 8'h03};

    always #50 clock = ~clock;

    mixer_amp_gain_control #(.RAMP_STEP(4)) u_mixer_amp_gain_control (
        .clock(clock), .resetn(resetn), .reg_address(reg_address),
        .reg_write_data(reg_write_data), .reg_write(reg_write),
        .reg_read(reg_read), .reg_read_data(reg_read_data),
        .zero_cross(zero_cross), .in_amp_a(in_amp_a), .in_amp_b(in_amp_b),
        .out_amp_left(out_amp_left), .out_amp_right(out_amp_right),
        .gain_busy(gain_busy));

    task automatic check(input string what, input logic [7:0] exp,
                         input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_db(input string what, input logic signed [8:0] exp,
                            input logic signed [8:0] got);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    function automatic logic signed [8:0] in_db(input logic [3:0] c);
        return 9'(-45 + 15 * int'(c));
    endfunction

    function automatic logic [7:0] out_db(input logic [1:0] c);
        return 8'(-15 + 5 * int'(c));
    endfunction

    // Bits that hold state in each register
    function automatic logic [7:0] mask(input logic [7:0] a);
        case (a)
            8'h2C, 8'h2E: return 8'hF8;
            8'h2D, 8'h2F: return 8'h0F;
            8'hCC, 8'hCE: return 8'h80;
            8'hCD, 8'hCF: return 8'h03;
            default: return 8'h00;
        endcase
    endfunction

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clock);
        reg_address <= a;
        reg_write_data <= v;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        reg_address <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1;
        check("read data", exp, reg_read_data);
    endtask

    task automatic end_of_test;
        $display("checks %0d errors %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clock);
        bad_count++;
        end_of_test();
    end

    initial begin
        void'($urandom(71));
        repeat (20) @(posedge clock);
        resetn <= 1'b1;
        #1;
        check("a powered", 8'h00, {7'h0, in_amp_a.powered});
        check("a silenced", 8'h01, {7'h0, in_amp_a.silenced});
        check("a mixing", 8'h01, {7'h0, in_amp_a.mixing});
        check("a gain", 8'h03, {4'h0, in_amp_a.gain_code});
        check("left powered", 8'h00, {7'h0, out_amp_left.powered});
        check("left gain", 8'h03, {6'h0, out_amp_left.gain_code});
        for (n = 0; n < 8; n++)
            rd(ofs[n], rst[n]);
        rd(8'h30, 8'h00);
        for (n = 0; n < 24; n++) begin
            d = 8'($urandom);
            if (mask(ofs[n % 8]) == 8'h03 && d[1:0] == 2'h0)
                d[0] = 1'b1;
            wr(ofs[n % 8], d);
            rd(ofs[n % 8], d & mask(ofs[n % 8]));
        end
        wr(8'h2C, 8'h88);
        repeat (4) @(posedge clock);
        #1;
        check("a enabled", 8'h01, {7'h0, in_amp_a.powered});
        check("a unmuted", 8'h00, {7'h0, in_amp_a.silenced});
        for (n = 0; n < 16; n++) begin
            wr(8'h2D, 8'(n));
            @(posedge clock);
            #1;
            check("instant gain", 8'(n), {4'h0, in_amp_a.gain_code});
            check_db("input dB", in_db(4'(n)), in_amp_a.gain_tenth_db);
        end
        wr(8'h2C, 8'hC0);
        #1;
        check("muted", 8'h01, {7'h0, in_amp_a.silenced});
        check("mix off", 8'h00, {7'h0, in_amp_a.mixing});
        wr(8'h2C, 8'hB8);
        wr(8'h2D, 8'h00);
        repeat (2) @(posedge clock);
        #1;
        check("ramp busy", 8'h01, {7'h0, gain_busy[0]});
        check("ramp start", 8'h01, {7'h0, in_amp_a.gain_code > 4'hC});
        n = 0;
        while (gain_busy[0] !== 1'b0 && n < 300) begin
            @(posedge clock);
            n++;
        end
        #1;
        check("ramp end", 8'h00, {4'h0, in_amp_a.gain_code});
        check("ramp done", 8'h00, {7'h0, gain_busy[0]});
        wr(8'h2E, 8'h88);
        wr(8'h2F, 8'h03);
        wr(8'h2E, 8'h98);
        wr(8'h2F, 8'h09);
        repeat (10) @(posedge clock);
        #1;
        check("held gain", 8'h03, {4'h0, in_amp_b.gain_code});
        check("wait busy", 8'h01, {7'h0, gain_busy[1]});
        @(posedge clock);
        zero_cross <= 2'h2;
        @(posedge clock);
        zero_cross <= 2'h0;
        #1;
        check("crossing gain", 8'h09, {4'h0, in_amp_b.gain_code});
        wr(8'hCC, 8'h80);
        wr(8'hCE, 8'h80);
        #1;
        check("outs on", 8'h03, {6'h0, out_amp_left.powered,
                                 out_amp_right.powered});
        for (n = 1; n < 4; n++) begin
            wr(8'hCD, 8'(n));
            wr(8'hCF, 8'(n));
            #1;
            check("left dB", out_db(2'(n)), out_amp_left.gain_tenth_db);
            check("right dB", out_db(2'(n)), out_amp_right.gain_tenth_db);
            check("left rsvd", 8'h00,
                  {7'h0, out_amp_left.gain_reserved});
            check("right rsvd", 8'h00,
                  {7'h0, out_amp_right.gain_reserved});
        end
        end_of_test();
    end
endmodule
